// >>> hdl/pyd_readout.sv
// Single-wire packet readout of a two-channel infrared detector front end.
// Assumes the converter results arrive on clk_sys; the link pin is asynchronous.
//
// Summary of operation
// - Packet is three 14-bit words: channel 1, channel 0, temperature.
// - One pin: device drives data out, host drives the bit clock in.
// - A conversion starts every 32 oscillator cycles.
// - Output latch takes new data only while pin low and idle.
// - Each host rising edge makes the device drive the next bit, 42 total.
// - Host may cancel after any bit by holding the pin low.
// - Device pulls the pin high every 512 oscillator cycles.
// - Out-of-range values short the converter input for 512 cycles.
module pyd_readout
    import pyd_pkg::*;
(
    // Clock and reset.
    input  wire  logic        clk_sys,
    input  wire  logic        rst_n,
    // Converter side.
    output logic              conv_start,
    input  wire  logic        sample_valid,
    output logic              sample_ready,
    input  wire  pyd_packet_s sample_data,
    output logic              adc_input_short,
    // Link pin as input, output and active-low enable.
    input  wire  logic        sensor_link_short_in,
    output logic              sensor_link_short_out,
    output logic              sensor_link_short_oe_n,
    // Status.
    output logic              readout_busy
);

    // Oscillator divider state.
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic             osc_tick;
    logic             next_osc_tick;

    // Conversion cadence and pull-high schedule.
    logic [4:0]       conv_cnt;
    logic [4:0]       next_conv_cnt;
    logic             next_conv_start;
    logic [8:0]       pull_cnt;
    logic [8:0]       next_pull_cnt;
    logic             pull_due;
    logic             next_pull_due;

    // Saturation recovery.
    logic [9:0]       short_cnt;
    logic [9:0]       next_short_cnt;
    logic             next_adc_input_short;
    logic             range_bad;

    // Link synchroniser.
    logic             link_s1;
    logic             link_s2;
    logic             link_d;
    logic             link_rise;

    // Readout sequencer.
    pyd_state_e           state;
    pyd_state_e           next_state;
    logic [PACKET_W-1:0]  latch;
    logic [PACKET_W-1:0]  next_latch;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [BIT_IDX_W-1:0] next_bit_idx;
    logic [1:0]           high_ticks;
    logic [1:0]           next_high_ticks;
    logic [DIV_W-1:0]     timer;
    logic [DIV_W-1:0]     next_timer;
    logic                 next_link_out;
    logic                 next_link_oe_n;
    logic                 next_busy;

    // Buffer between converter and latch.
    logic                 buf_valid;
    logic                 buf_ready;
    logic [PACKET_W-1:0]  buf_data;

    pyd_fifo #(
        .WIDTH (PACKET_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    // The slow oscillator is modelled as a one-cycle enable every 1562 system cycles.
    always_comb begin
        next_osc_tick = (div_cnt == DIV_W'(OSC_DIV_CYC - 1));
        next_div_cnt  = next_osc_tick ? '0 : div_cnt + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt  <= '0;
            osc_tick <= 1'b0;
        end else begin
            div_cnt  <= next_div_cnt;
            osc_tick <= next_osc_tick;
        end
    end

    // Conversion cadence and pull-high schedule, both counted in oscillator ticks.
    always_comb begin
        next_conv_cnt   = conv_cnt;
        next_conv_start = 1'b0;
        next_pull_cnt   = pull_cnt;
        // The request stays pending until the sequencer is idle and takes it;
        // a new request on the same tick as the clear still wins.
        next_pull_due   = (state == ST_PULL) ? 1'b0 : pull_due;
        if (osc_tick) begin
            next_conv_cnt   = (conv_cnt == CONV_TICKS) ? 5'h00 : conv_cnt + 1'b1;
            next_conv_start = (conv_cnt == CONV_TICKS);
            next_pull_cnt   = pull_cnt + 1'b1;
            if (pull_cnt == PULL_TICKS) begin
                next_pull_due = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt   <= '0;
            conv_start <= 1'b0;
            pull_cnt   <= '0;
            pull_due   <= 1'b0;
        end else begin
            conv_cnt   <= next_conv_cnt;
            conv_start <= next_conv_start;
            pull_cnt   <= next_pull_cnt;
            pull_due   <= next_pull_due;
        end
    end

    // Range check on both channel words as they are accepted from the converter.
    always_comb begin
        range_bad = (sample_data.ch1_word > RANGE_HI) || (sample_data.ch1_word < RANGE_LO)
                 || (sample_data.ch0_word > RANGE_HI) || (sample_data.ch0_word < RANGE_LO);
        next_short_cnt = short_cnt;
        if (sample_valid && sample_ready && range_bad) begin
            next_short_cnt = SHORT_TICKS;
        end else if (osc_tick && short_cnt != '0) begin
            next_short_cnt = short_cnt - 1'b1;
        end
        next_adc_input_short = (next_short_cnt != '0);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            short_cnt       <= '0;
            adc_input_short <= 1'b0;
        end else begin
            short_cnt       <= next_short_cnt;
            adc_input_short <= next_adc_input_short;
        end
    end

    // Two flip-flops bring the pin into clk_sys; a third stage feeds edge detection.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            link_d  <= 1'b0;
        end else begin
            link_s1 <= sensor_link_short_in;
            link_s2 <= link_s1;
            link_d  <= link_s2;
        end
    end

    assign link_rise = link_s2 && !link_d;

    // Readout sequencer; while the device drives the pin it ignores what it sees there.
    always_comb begin
        next_state      = state;
        next_latch      = latch;
        next_bit_idx    = bit_idx;
        next_high_ticks = high_ticks;
        next_timer      = timer;
        next_link_out   = sensor_link_short_out;
        next_link_oe_n  = sensor_link_short_oe_n;
        buf_ready       = 1'b0;
        unique case (state)
            ST_IDLE: begin
                next_link_oe_n = 1'b1;
                if (!link_s2) begin
                    next_high_ticks = '0;
                    // Latch only when low and idle.
                    buf_ready = 1'b1;
                    // Whole packet, channel 1 word on top.
                    if (buf_valid) begin
                        next_latch = buf_data;
                    end
                end else if (osc_tick) begin
                    next_high_ticks = high_ticks + 1'b1;
                end
                // Three ticks high starts a readout.
                if (link_s2 && osc_tick && high_ticks == SETUP_TICKS - 2'h1) begin
                    next_state   = ST_WAIT;
                    next_bit_idx = FIRST_BIT;
                    next_timer   = '0;
                end else if (pull_due && !link_s2) begin
                    next_state     = ST_PULL;
                    next_timer     = DIV_W'(OSC_DIV_CYC);
                    next_link_out  = 1'b1;
                    next_link_oe_n = 1'b0;
                end
            end
            ST_WAIT: begin
                // Each host rising edge sends one bit.
                if (link_rise) begin
                    next_state     = ST_DRIVE;
                    next_link_out  = latch[bit_idx];
                    // Device drives here to send data; it also drives the pin high in ST_PULL.
                    next_link_oe_n = 1'b0;
                    next_timer     = DIV_W'(BIT_HOLD_CYC);
                end else if (!link_s2) begin
                    // A long low cancels the readout.
                    next_timer = timer + 1'b1;
                    if (timer == DIV_W'(LOW_MAX_CYC)) begin
                        next_state = ST_IDLE;
                    end
                end else begin
                    next_timer = '0;
                end
            end
            ST_DRIVE: begin
                next_timer = timer - 1'b1;
                if (timer == DIV_W'(1)) begin
                    next_link_oe_n = 1'b1;
                    next_timer     = '0;
                    if (bit_idx == LAST_BIT) begin
                        next_state = ST_TAIL;
                    end else begin
                        next_state   = ST_WAIT;
                        next_bit_idx = bit_idx - 1'b1;
                    end
                end
            end
            ST_TAIL: begin
                // Host low after bit 0 ends the packet.
                if (!link_s2) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PULL: begin
                next_timer = timer - 1'b1;
                if (timer == DIV_W'(1)) begin
                    next_link_oe_n = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
            default: begin
                next_state     = ST_IDLE;
                next_link_oe_n = 1'b1;
            end
        endcase
        if (next_state == ST_IDLE) begin
            next_high_ticks = (state == ST_IDLE) ? next_high_ticks : 2'h0;
        end
        next_busy = (next_state == ST_WAIT) || (next_state == ST_DRIVE)
                 || (next_state == ST_TAIL);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state                  <= ST_IDLE;
            latch                  <= '0;
            bit_idx                <= FIRST_BIT;
            high_ticks             <= '0;
            timer                  <= '0;
            sensor_link_short_out  <= 1'b0;
            sensor_link_short_oe_n <= 1'b1;
            readout_busy           <= 1'b0;
        end else begin
            state                  <= next_state;
            latch                  <= next_latch;
            bit_idx                <= next_bit_idx;
            high_ticks             <= next_high_ticks;
            timer                  <= next_timer;
            sensor_link_short_out  <= next_link_out;
            sensor_link_short_oe_n <= next_link_oe_n;
            readout_busy           <= next_busy;
        end
    end

endmodule : pyd_readout

// >>> hdl/pyd_pkg.sv
// Shared constants and types for the pyroelectric detector readout block.
// Assumes a 50 MHz system clock and a slow on-chip oscillator derived from it.
package pyd_pkg;

    // Word layout of one packet.
    localparam int WORD_W    = 14;
    localparam int PACKET_W  = 3 * WORD_W;
    localparam int BIT_IDX_W = 6;
    localparam logic [BIT_IDX_W-1:0] FIRST_BIT = 6'h29;   // Index 41, sent first.
    localparam logic [BIT_IDX_W-1:0] LAST_BIT  = 6'h00;

    // Clock and slow oscillator timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int OSC_PERIOD_NS = 31250;                  // 32 kHz typical.
    localparam int OSC_DIV_CYC   = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 11;

    // Longest low time on the link before a readout is taken as ended.
    localparam int LOW_MAX_NS    = 25000;
    localparam int LOW_MAX_CYC   = LOW_MAX_NS / CLK_PERIOD_NS;

    // Time the device drives a data bit after each host rising edge.
    localparam int BIT_HOLD_NS   = 4000;
    localparam int BIT_HOLD_CYC  = (BIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Oscillator cycle counts.
    localparam logic [4:0] CONV_TICKS      = 5'h1f;        // 32 ticks per conversion.
    localparam logic [1:0] SETUP_TICKS     = 2'h3;         // Least high time for a request.
    localparam logic [8:0] PULL_TICKS      = 9'h1ff;       // Pull high every 512 ticks.
    localparam logic [9:0] SHORT_TICKS     = 10'h200;      // Input short lasts 512 ticks.

    // Out-of-range limits of a converted channel value.
    localparam logic [WORD_W-1:0] RANGE_HI = 14'h3e00;     // 15872 counts.
    localparam logic [WORD_W-1:0] RANGE_LO = 14'h01ff;     // 511 counts.

    // Depth of the sample buffer.
    localparam int FIFO_DEPTH = 16;

    // One conversion result, most significant word first on the link.
    typedef struct packed {
        logic [WORD_W-1:0] ch1_word;
        logic [WORD_W-1:0] ch0_word;
        logic [WORD_W-1:0] ambient_temp_word;
    } pyd_packet_s;

    // Readout sequencer states.
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WAIT  = 5'b00010,
        ST_DRIVE = 5'b00100,
        ST_TAIL  = 5'b01000,
        ST_PULL  = 5'b10000
    } pyd_state_e;

endpackage : pyd_pkg

// >>> hdl/pyd_fifo.sv
// Synchronous first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on the same clock; in_ready comes from a flip-flop.
module pyd_fifo #(
    parameter int WIDTH = 42,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire  logic             clk_sys,
    input  wire  logic             rst_n,
    // Filling side.
    input  wire  logic             in_valid,
    output logic                   in_ready,
    input  wire  logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                   out_valid,
    input  wire  logic             out_ready,
    output logic [WIDTH-1:0]       out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_in_ready;
    logic             do_wr;
    logic             do_rd;

    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // Pointer and occupancy update; ready is registered so it is honest a cycle ahead.
    always_comb begin
        do_wr         = in_valid && in_ready;
        do_rd         = out_valid && out_ready;
        next_wr_ptr   = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr   = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count    = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        next_in_ready = (next_count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            count    <= next_count;
            in_ready <= next_in_ready;
        end
    end

    // Storage has no reset; only entries below count are ever read out.
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : pyd_fifo

// >>> bench/pyd_readout_asserts.sv
// Port checker for the pyd_readout block.
// Assumes the bind below and one clock domain with an async low reset.
module pyd_readout_asserts
    import pyd_pkg::*;
(
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Converter side.
    input wire logic        conv_start,
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire pyd_packet_s sample_data,
    input wire logic        adc_input_short,
    // Link pin and status.
    input wire logic        sensor_link_short_in,
    input wire logic        sensor_link_short_out,
    input wire logic        sensor_link_short_oe_n,
    input wire logic        readout_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    wire logic   lin = sensor_link_short_in;
    wire logic   oe_n = sensor_link_short_oe_n;
    logic        seen, next_seen;
    logic [15:0] conv_cnt, next_conv_cnt;
    logic [7:0]  drv_cnt, next_drv_cnt;
    logic [10:0] low_cnt, next_low_cnt;
    logic [12:0] hi_cnt, next_hi_cnt;
    logic [19:0] sh_cnt, next_sh_cnt;
    logic        oor;

    // A taken word with a channel outside the limits; temperature is not judged.
    assign oor = sample_valid && sample_ready &&
        (sample_data.ch1_word > RANGE_HI || sample_data.ch1_word < RANGE_LO ||
         sample_data.ch0_word > RANGE_HI || sample_data.ch0_word < RANGE_LO);

    // Span counters; low_cnt and hi_cnt saturate so they never wrap to a false match.
    // The low span counts only while the device is off the pin, as its cancel timer does.
    always_comb begin
        next_seen     = seen | conv_start;
        next_conv_cnt = conv_start ? 16'h0000 : conv_cnt + 16'h0001;
        next_drv_cnt  = oe_n ? 8'h00 : drv_cnt + 8'h01;
        next_low_cnt  = (lin || !oe_n) ? 11'h000 : low_cnt + {10'h000, ~&low_cnt};
        next_hi_cnt   = lin ? hi_cnt + {12'h000, ~&hi_cnt} : 13'h0000;
        next_sh_cnt   = adc_input_short ? sh_cnt + 20'h00001 : 20'h00000;
    end

    // Registers of the span counters.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {seen, conv_cnt, drv_cnt, low_cnt, hi_cnt, sh_cnt} <= '0;
        end else begin
            seen     <= next_seen;
            conv_cnt <= next_conv_cnt;
            drv_cnt  <= next_drv_cnt;
            low_cnt  <= next_low_cnt;
            hi_cnt   <= next_hi_cnt;
            sh_cnt   <= next_sh_cnt;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Relations between the block's causes and its outputs.
    chk_reset_rest: assert property (
        $rose(rst_n) |-> sample_ready && oe_n && !readout_busy && !conv_start)
        else $error("Outputs not at rest after reset.");
    chk_conv_period: assert property (
        conv_start && seen |-> conv_cnt == 16'hc33f)
        else $error("Conversion interval wrong.");
    chk_bit_hold: assert property (
        $rose(oe_n) && readout_busy |-> drv_cnt == 8'hc8)
        else $error("Data bit not held for its span.");
    chk_edge_drive: assert property (
        $rose(lin) && readout_busy && oe_n |-> ##[1:4] !oe_n)
        else $error("No data bit after a host edge.");
    chk_short_rise: assert property (
        oor |-> ##[1:2] adc_input_short)
        else $error("Input not shorted after out-of-range word.");
    chk_short_cause: assert property (
        $rose(adc_input_short) |-> $past(oor) || $past(oor, 2))
        else $error("Input shorted without cause.");
    chk_short_hold: assert property (
        $fell(adc_input_short) |-> sh_cnt > 20'hc2de6)
        else $error("Input short ended early.");
    chk_cancel_end: assert property (
        low_cnt == 11'h4ec |-> !readout_busy)
        else $error("Readout not ended by a long low.");
    chk_setup_long: assert property (
        $rose(readout_busy) |-> hi_cnt > 13'h0c1c)
        else $error("Readout began before the setup time.");
    chk_pull_high: assert property (
        !oe_n && !readout_busy |-> sensor_link_short_out)
        else $error("Device drove the pin low outside a readout.");
endmodule : pyd_readout_asserts

bind pyd_readout pyd_readout_asserts pyd_readout_asserts_i (.clk_sys, .rst_n, .conv_start,
    .sample_valid, .sample_ready, .sample_data, .adc_input_short, .sensor_link_short_in,
    .sensor_link_short_out, .sensor_link_short_oe_n, .readout_busy);

// >>> bench/pyd_host_model.sv
// Behavioural host that clocks packets out of the single-wire link.
// Assumes the bench resolves the pin from host_en, host_val and the device.
module pyd_host_model (
    // Clock and resolved pin level.
    input  wire logic clk_sys,
    input  wire logic link,
    // Host drive of the pin.
    output logic      host_en,
    output logic      host_val
);
    timeunit 1ns;
    timeprecision 1ps;

    // The host leaves the pin released until it is asked to read.
    initial begin
        host_en  = 1'b0;
        host_val = 1'b0;
    end

    // Holds the pin high past the setup time, then drives it low.
    task automatic request();
        @(negedge clk_sys);
        host_en  = 1'b1;
        host_val = 1'b1;
        repeat (16'h1388) @(negedge clk_sys);
        host_val = 1'b0;
    endtask : request

    // Short pulses keep every low span brief.
    // The pulse ends before the device drives, so the two never fight.
    task automatic read_bits(input int n, output logic [41:0] got);
        got = '0;
        for (int i = 41; i > 41 - n; i--) begin
            @(negedge clk_sys);
            host_en  = 1'b1;
            host_val = 1'b1;
            repeat (8'h02) @(negedge clk_sys);
            host_en = 1'b0;
            repeat (8'h64) @(negedge clk_sys);
            got[i] = link;
            repeat (8'h96) @(negedge clk_sys);
            host_en  = 1'b1;
            host_val = 1'b0;
        end
    endtask : read_bits

    // Drives the pin low for a span, then releases it.
    task automatic finish(input int span);
        @(negedge clk_sys);
        host_en  = 1'b1;
        host_val = 1'b0;
        repeat (span) @(negedge clk_sys);
        host_en = 1'b0;
    endtask : finish
endmodule : pyd_host_model

// >>> bench/pyd_readout_tb.sv
// Self-checking bench for pyd_readout with a behavioural host on the link.
// Assumes the bound port checker; the released pin is held low by a pull-down.
module pyd_readout_tb
    import pyd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        sample_valid = 1'b0;
    pyd_packet_s sample_data = '0;
    logic        conv_start, sample_ready, adc_input_short, readout_busy;
    logic        link_out, link_oe_n, host_en, host_val;
    wire logic   link;
    int          mismatches = 0;
    int          compares = 0;
    pyd_packet_s last;
    logic [41:0] got;

    // Clock and the resolved pin: device first, then host, else the pull-down.
    always #10 clk_sys = ~clk_sys;
    assign link = !link_oe_n ? link_out : host_en ? host_val : 1'b0;

    // Device under test and its host.
    pyd_readout pyd_readout_i (.clk_sys, .rst_n, .conv_start, .sample_valid, .sample_ready,
        .sample_data, .adc_input_short, .sensor_link_short_in(link),
        .sensor_link_short_out(link_out), .sensor_link_short_oe_n(link_oe_n), .readout_busy);
    pyd_host_model pyd_host_model_i (.clk_sys, .link, .host_en, .host_val);

    // Counts one comparison and reports a mismatch.
    task automatic check(input logic [41:0] act, input logic [41:0] exp);
        compares++;
        if (act !== exp) begin
            mismatches++;
            $display("BAD t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask : check

    task automatic check1(input logic act, input logic exp);
        check({41'h0, act}, {41'h0, exp});
    endtask : check1

    // In-range test word; channels stay well inside the limits.
    function automatic pyd_packet_s word(input logic [13:0] k);
        word = '{14'h2000 + k, 14'h1000 + k, k};
    endfunction : word

    task automatic summarize();
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // Rest values just after reset.
    task automatic t_reset();
        @(negedge clk_sys);
        check({37'h0, sample_ready, link_oe_n, readout_busy, adc_input_short, conv_start},
              {37'h0, 5'h18});
    endtask : t_reset

    // Fill the buffer during a request, read, drain, then read and cancel.
    task automatic t_link();
        @(negedge clk_sys);
        last = word(14'h0007);
        sample_data = last;
        sample_valid = 1'b1;
        @(negedge clk_sys);
        sample_valid = 1'b0;
        repeat (8'h08) @(negedge clk_sys);
        fork
            pyd_host_model_i.request();
            begin
                repeat (8'h10) @(negedge clk_sys);
                for (int i = 0; i < 17; i++) begin
                    check1(sample_ready, i < 16);
                    sample_data = word(14'h0100 + 14'(i));
                    sample_valid = 1'b1;
                    @(negedge clk_sys);
                end
                check1(sample_ready, 1'b0);
                sample_valid = 1'b0;
            end
        join
        check1(readout_busy, 1'b1);
        pyd_host_model_i.read_bits(42, got);
        check(got, last);
        pyd_host_model_i.finish(8'h0a);
        for (int i = 0; i < 40 && sample_ready !== 1'b1; i++) @(negedge clk_sys);
        check1(readout_busy, 1'b0);
        check1(sample_ready, 1'b1);
        last = word(14'h010f);
        pyd_host_model_i.request();
        pyd_host_model_i.read_bits(28, got);
        check1(readout_busy, 1'b1);
        check({got[41:14], 14'h0}, {last[41:14], 14'h0});
        pyd_host_model_i.finish(16'h0578);
        check1(readout_busy, 1'b0);
    endtask : t_link

    // Boundary words leave the input alone; one count past a limit shorts it.
    task automatic t_range();
        @(negedge clk_sys);
        sample_valid = 1'b1;
        sample_data = '{RANGE_HI, RANGE_LO, 14'h0000};
        @(negedge clk_sys);
        sample_data = '{RANGE_LO, RANGE_HI, 14'h3fff};
        @(negedge clk_sys);
        sample_valid = 1'b0;
        repeat (8'h03) @(negedge clk_sys);
        check1(adc_input_short, 1'b0);
        sample_valid = 1'b1;
        sample_data = '{RANGE_HI, RANGE_LO - 14'h0001, 14'h0000};
        @(negedge clk_sys);
        sample_valid = 1'b0;
        repeat (8'h03) @(negedge clk_sys);
        check1(adc_input_short, 1'b1);
        repeat (16'h1000) @(negedge clk_sys);
        check1(adc_input_short, 1'b1);
    endtask : t_range

    // Cycles between two conversion starts.
    task automatic t_conv();
        int n;
        repeat (2) begin
            n = 0;
            @(negedge clk_sys);
            while (conv_start !== 1'b1 && n < 17'h0d000) begin
                n++;
                @(negedge clk_sys);
            end
        end
        check(42'(n), 42'h0c33f);
    endtask : t_conv

    // Reset for three cycles, then the scenarios beside the cadence check.
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reset();
        fork
            t_conv();
            begin
                t_link();
                t_range();
            end
        join
        summarize();
    end

    // Watchdog sized to the conversion check, the longest scenario.
    initial begin
        repeat (17'h1d4c0) @(posedge clk_sys);
        mismatches++;
        summarize();
    end
endmodule : pyd_readout_tb
